// ### rtl/adcp_regs.svh
// register layout, command fields, reset values and timing figures
`ifndef ADCP_REGS_SVH
`define ADCP_REGS_SVH

// word sizes
`define ADCP_CMD_W        8
`define ADCP_REG_W        24
`define ADCP_GRP_W        72
`define ADCP_CNT_W        7
`define ADCP_CMD_LAST     7'h07
`define ADCP_REG_LAST     7'h17
`define ADCP_GRP_LAST     7'h47

// command byte fields
`define ADCP_CMD_EXEC     7
`define ADCP_CMD_SC       6
`define ADCP_CMD_CC       5
`define ADCP_CMD_RD       4
`define ADCP_CMD_SEL      3:1
`define ADCP_CMD_PS       0

// register select codes
`define ADCP_SEL_OFFSET   3'h0
`define ADCP_SEL_GAIN     3'h1
`define ADCP_SEL_SETUP    3'h2
`define ADCP_SEL_RESULT   3'h3
`define ADCP_SEL_GROUP    3'h4

// reset values; gain is unsigned 2.22 fixed point
`define ADCP_OFFSET_RST   24'h000000
`define ADCP_GAIN_RST     24'h400000
`define ADCP_GAIN_MAX     24'hFFFFFF
`define ADCP_SETUP_RST    24'h000000
`define ADCP_GAIN_FRAC    22

// word rate select field in setup_options
`define ADCP_CFG_RATE     2:0

// nominal master clock and word rates in milli-samples per second
`define ADCP_XIN_HZ       32768
`define ADCP_OWR0_MSPS    1880
`define ADCP_OWR1_MSPS    3760
`define ADCP_OWR2_MSPS    7510
`define ADCP_OWR3_MSPS    15000
`define ADCP_OWR4_MSPS    30000
`define ADCP_OWR5_MSPS    61600
`define ADCP_OWR6_MSPS    84500
`define ADCP_OWR7_MSPS    101100
`define ADCP_MSPS_PER_SPS 1000

`endif

// ### rtl/adcp_pkg.sv
// types shared by the serial command port and its word rate generator
package adcp_pkg;

   typedef enum logic [0:0] {
      ADCP_CMD_MODE  = 1'b0,
      ADCP_DATA_MODE = 1'b1
   } adcp_link_mode_e;

   typedef enum logic [1:0] {
      ADCP_IDLE   = 2'b00,
      ADCP_SINGLE = 2'b01,
      ADCP_CONT   = 2'b10
   } adcp_conv_mode_e;

   typedef logic [23:0] adcp_word_t;

   // per-frame shift state, cleared whenever chip select is released
   typedef struct packed {
      adcp_link_mode_e mode;
      logic [6:0]      cnt;
      logic [7:0]      cmd;
      logic [71:0]     sh;
      logic            rd_busy;
   } adcp_frame_s;

   // link-side registers that survive between frames
   typedef struct packed {
      adcp_word_t offset_calibration;
      adcp_word_t gain_calibration;
      adcp_word_t setup_options;
      logic       wr_tog;
      logic [2:0] conv_cmd;
      logic       conv_tog;
      logic [1:0] ce_sync;
   } adcp_cal_s;

   // system clock side state
   typedef struct packed {
      logic [2:0]      wr_sync;
      logic [2:0]      cv_sync;
      logic [1:0]      rd_sync;
      adcp_word_t      offset_calibration;
      adcp_word_t      gain_calibration;
      adcp_word_t      setup_options;
      adcp_conv_mode_e mode;
      logic            pend;
      adcp_word_t      pend_word;
      adcp_word_t      result_word;
      logic            result_ready;
      logic            conv_active;
   } adcp_sys_s;

   typedef struct packed {
      logic [2:0]  xin_sync;
      logic [14:0] cnt;
      logic        tick;
   } adcp_rate_s;

endpackage

// ### rtl/adcp_rate_if.sv
// link between the port core and the word rate generator
`timescale 1ns/1ps
interface adcp_rate_if;
   logic [2:0] rate_sel;
   logic       run;
   logic       tick;

   modport gen  (input rate_sel, input run, output tick);
   modport user (output rate_sel, output run, input tick);
endinterface

// ### rtl/adcp_rate_gen.sv
// conversion word rate generator paced by the master clock input
`timescale 1ns/1ps
`include "adcp_regs.svh"
module adcp_rate_gen #(
   parameter int DIV_W = 15
) (
   input  wire logic  sys_clk,
   input  wire logic  reset,
   input  wire logic  ce,
   input  wire logic  master_clock_input,
   adcp_rate_if.gen   rate
);

   if (DIV_W < 15) begin : g_bad_width
      $error("adcp_rate_gen: DIV_W too small for slowest word rate");
   end

   adcp_pkg::adcp_rate_s st;
   adcp_pkg::adcp_rate_s next_st;

   // master clock periods per conversion, rounded to nearest
   function automatic logic [DIV_W-1:0] period_of(input logic [2:0] sel);
      int msps;
      case (sel)
         3'h0:    msps = `ADCP_OWR0_MSPS;
         3'h1:    msps = `ADCP_OWR1_MSPS;
         3'h2:    msps = `ADCP_OWR2_MSPS;
         3'h3:    msps = `ADCP_OWR3_MSPS; // 15 Sps and below
         3'h4:    msps = `ADCP_OWR4_MSPS;
         3'h5:    msps = `ADCP_OWR5_MSPS;
         3'h6:    msps = `ADCP_OWR6_MSPS;
         default: msps = `ADCP_OWR7_MSPS;
      endcase
      period_of = DIV_W'((`ADCP_XIN_HZ * `ADCP_MSPS_PER_SPS + msps / 2)
                         / msps);
   endfunction

   // count master clock edges; a tick ends each conversion period
   always_comb begin
      next_st = st;
      if (ce) begin
         next_st.xin_sync = {st.xin_sync[1:0], master_clock_input};
         next_st.tick     = 1'b0;
         if (!rate.run) begin
            next_st.cnt = '0; // restart so the first word is fully settled
         end else if (st.xin_sync[1] && !st.xin_sync[2]) begin
            // period counted in master clock cycles scales with it
            if (st.cnt == period_of(rate.rate_sel) - DIV_W'(1)) begin
               next_st.cnt  = '0; // one of eight selectable rates
               next_st.tick = 1'b1;
            end else begin
               next_st.cnt = st.cnt + DIV_W'(1);
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rate.tick = st.tick;

endmodule

// ### rtl/adcp_serial_port.sv
// serial command port with calibration registers and conversion pacing
`timescale 1ns/1ps
`include "adcp_regs.svh"
module adcp_serial_port #(
   parameter int DIV_W = 15
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic        master_clock_input,
   input  wire logic [23:0] adc_sample,
   input  wire logic        serial_clock,
   input  wire logic        chip_select_n,
   input  wire logic        serial_data_in,
   output logic             serial_data_out,
   output logic             serial_data_oe,
   output logic [23:0]      result_word,
   output logic             result_ready,
   output logic             conv_active,
   output logic [23:0]      setup_options
);

   if (DIV_W < 15) begin : g_bad_width
      $error("adcp_serial_port: DIV_W too small for slowest word rate");
   end

   adcp_pkg::adcp_frame_s frm;
   adcp_pkg::adcp_frame_s next_frm;
   adcp_pkg::adcp_cal_s   cal;
   adcp_pkg::adcp_cal_s   next_cal;
   adcp_pkg::adcp_sys_s   s;
   adcp_pkg::adcp_sys_s   next_s;
   logic                  frame_reset;
   logic                  sdo_q;
   logic                  sdo_oe_q;
   logic [7:0]            cmd_byte;
   logic                  link_ce;
   adcp_rate_if           rate ();

   // a command that starts, continues or stops conversions
   function automatic logic is_conv_cmd(input logic [7:0] c);
      is_conv_cmd = c[`ADCP_CMD_SC] | c[`ADCP_CMD_CC] | c[`ADCP_CMD_PS];
   endfunction

   // select codes that own a data phase
   function automatic logic is_reg_sel(input logic [2:0] sel);
      is_reg_sel = (sel <= `ADCP_SEL_GROUP);
   endfunction

   // offset removal and gain scaling, clipped to the signed result range
   function automatic adcp_pkg::adcp_word_t calibrate(
      input adcp_pkg::adcp_word_t raw,
      input adcp_pkg::adcp_word_t off,
      input adcp_pkg::adcp_word_t gain
   );
      logic signed [24:0] diff;
      logic signed [49:0] prod;
      logic signed [27:0] scaled;
      diff   = $signed({raw[23], raw}) - $signed({off[23], off});
      prod   = diff * $signed({1'b0, gain});
      scaled = 28'(prod >>> `ADCP_GAIN_FRAC);
      if (scaled > 28'sh07FFFFF) begin
         calibrate = 24'h7FFFFF;
      end else if (scaled < -28'sh0800000) begin
         calibrate = 24'h800000;
      end else begin
         calibrate = scaled[23:0];
      end
   endfunction

   // chip select release ends the frame on the link side
   assign frame_reset = reset | chip_select_n;
   assign cmd_byte    = {frm.sh[6:0], serial_data_in};
   assign link_ce     = cal.ce_sync[1];

   // link side: command decode and data shifting on the serial clock
   always_comb begin
      next_frm = frm;
      next_cal = cal;
      next_cal.ce_sync = {cal.ce_sync[0], ce};
      if (link_ce) begin
         // each rising edge while link_ce is set shifts one input bit in, msb first
         next_frm.sh  = {frm.sh[70:0], serial_data_in};
         next_frm.cnt = frm.cnt + `ADCP_CNT_W'(1);
         case (frm.mode)
            adcp_pkg::ADCP_CMD_MODE: begin
               // the first eight bits form the command byte
               if (frm.cnt == `ADCP_CMD_LAST) begin
                  next_frm.cnt = '0;
                  if (!cmd_byte[`ADCP_CMD_EXEC]) begin
                     next_frm.mode = adcp_pkg::ADCP_CMD_MODE;
                  end else if (is_conv_cmd(cmd_byte)) begin
                     next_cal.conv_cmd = {cmd_byte[`ADCP_CMD_SC],
                                          cmd_byte[`ADCP_CMD_CC],
                                          cmd_byte[`ADCP_CMD_PS]};
                     next_cal.conv_tog = ~cal.conv_tog;
                  end else if (is_reg_sel(cmd_byte[`ADCP_CMD_SEL])) begin
                     next_frm.mode = adcp_pkg::ADCP_DATA_MODE;
                     next_frm.cmd  = cmd_byte;
                     if (cmd_byte[`ADCP_CMD_RD]) begin
                        case (cmd_byte[`ADCP_CMD_SEL])
                           `ADCP_SEL_OFFSET: next_frm.sh =
                              {cal.offset_calibration, 48'h0};
                           `ADCP_SEL_GAIN: next_frm.sh =
                              {cal.gain_calibration, 48'h0};
                           `ADCP_SEL_SETUP: next_frm.sh =
                              {cal.setup_options, 48'h0};
                           `ADCP_SEL_RESULT: begin
                              next_frm.sh = {s.result_word, 48'h0};
                              next_frm.rd_busy = 1'b1;
                           end
                           default: next_frm.sh =
                              {cal.offset_calibration,
                               cal.gain_calibration,
                               cal.setup_options};
                        endcase
                     end
                  end
                  // reserved select codes leave the port in command mode
               end
            end
            adcp_pkg::ADCP_DATA_MODE: begin
               // group phase is 72 clocks, single register 24
               if ((frm.cmd[`ADCP_CMD_SEL] == `ADCP_SEL_GROUP &&
                    frm.cnt == `ADCP_GRP_LAST) ||
                   (frm.cmd[`ADCP_CMD_SEL] != `ADCP_SEL_GROUP &&
                    frm.cnt == `ADCP_REG_LAST)) begin
                  next_frm.mode    = adcp_pkg::ADCP_CMD_MODE;
                  next_frm.cnt     = '0;
                  next_frm.rd_busy = 1'b0;
                  if (!frm.cmd[`ADCP_CMD_RD]) begin
                     next_cal.wr_tog = ~cal.wr_tog;
                     case (frm.cmd[`ADCP_CMD_SEL])
                        `ADCP_SEL_OFFSET:
                           next_cal.offset_calibration = next_frm.sh[23:0];
                        `ADCP_SEL_GAIN: // full 2.22 range ends at 3.999
                           next_cal.gain_calibration = next_frm.sh[23:0];
                        `ADCP_SEL_SETUP:
                           next_cal.setup_options = next_frm.sh[23:0];
                        `ADCP_SEL_GROUP: begin
                           next_cal.offset_calibration = next_frm.sh[71:48];
                           next_cal.gain_calibration   = next_frm.sh[47:24];
                           next_cal.setup_options      = next_frm.sh[23:0];
                        end
                        default: next_cal.wr_tog = cal.wr_tog;
                     endcase
                  end
               end
            end
            default: begin
               next_frm.mode = adcp_pkg::ADCP_CMD_MODE;
               next_frm.cnt  = '0;
            end
         endcase
      end
   end

   // frame state starts over in command mode at reset or deselect
   always_ff @(posedge serial_clock or posedge frame_reset) begin
      if (frame_reset) begin
         frm <= '0;
      end else begin
         frm <= next_frm;
      end
   end

   // link registers; gain loads 1.0 at reset
   always_ff @(posedge serial_clock or posedge reset) begin
      if (reset) begin
         cal.offset_calibration <= `ADCP_OFFSET_RST;
         cal.gain_calibration   <= `ADCP_GAIN_RST;
         cal.setup_options      <= `ADCP_SETUP_RST;
         cal.wr_tog             <= 1'b0;
         cal.conv_cmd           <= 3'h0;
         cal.conv_tog           <= 1'b0;
         cal.ce_sync            <= 2'h0;
      end else begin
         cal <= next_cal;
      end
   end

   // read data changes on the falling edge, msb first
   always_ff @(negedge serial_clock or posedge frame_reset) begin
      if (frame_reset) begin
         sdo_q    <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else if (link_ce) begin
         sdo_oe_q <= 1'b1;
         if (frm.mode == adcp_pkg::ADCP_DATA_MODE &&
             frm.cmd[`ADCP_CMD_RD]) begin
            sdo_q <= frm.sh[71];
         end else begin
            sdo_q <= 1'b0;
         end
      end
   end

   // word rate generator paced by the master clock
   adcp_rate_gen #(
      .DIV_W (DIV_W)
   ) u_rate (
      .sys_clk            (sys_clk),
      .reset              (reset),
      .ce                 (ce),
      .master_clock_input (master_clock_input),
      .rate               (rate.gen)
   );

   assign rate.rate_sel = s.setup_options[`ADCP_CFG_RATE];
   assign rate.run      = (s.mode != adcp_pkg::ADCP_IDLE);

   // system side: take link toggles, run conversions, publish results
   always_comb begin
      next_s = s;
      if (ce) begin
         next_s.wr_sync      = {s.wr_sync[1:0], cal.wr_tog};
         next_s.cv_sync      = {s.cv_sync[1:0], cal.conv_tog};
         next_s.rd_sync      = {s.rd_sync[0], frm.rd_busy};
         next_s.result_ready = 1'b0;
         // link words are stable long after their toggle arrives
         if (s.wr_sync[2] != s.wr_sync[1]) begin
            next_s.offset_calibration = cal.offset_calibration;
            next_s.gain_calibration   = cal.gain_calibration;
            next_s.setup_options      = cal.setup_options;
         end
         if (s.cv_sync[2] != s.cv_sync[1]) begin
            if (cal.conv_cmd[0]) begin
               next_s.mode = adcp_pkg::ADCP_IDLE;
            end else if (cal.conv_cmd[1]) begin
               next_s.mode = adcp_pkg::ADCP_CONT;
            end else begin
               next_s.mode = adcp_pkg::ADCP_SINGLE;
            end
         end
         // each period end while converting yields one settled word; a pending word not yet published is overwritten
         if (rate.tick && s.mode != adcp_pkg::ADCP_IDLE) begin
            next_s.pend      = 1'b1;
            next_s.pend_word = calibrate(adc_sample, s.offset_calibration,
                                         s.gain_calibration);
            if (s.mode == adcp_pkg::ADCP_SINGLE) begin
               next_s.mode = adcp_pkg::ADCP_IDLE;
            end
         end
         // hold the published word while the host is shifting it out
         if (s.pend && !s.rd_sync[1]) begin
            next_s.pend         = 1'b0;
            next_s.result_word  = s.pend_word;
            next_s.result_ready = 1'b1;
         end
         // a finished word still waiting to publish keeps activity up
         next_s.conv_active = (next_s.mode != adcp_pkg::ADCP_IDLE) ||
                              next_s.pend;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s                    <= '0;
         s.gain_calibration   <= `ADCP_GAIN_RST;
         s.offset_calibration <= `ADCP_OFFSET_RST;
         s.setup_options      <= `ADCP_SETUP_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs come straight from flip-flops
   assign serial_data_out = sdo_q;
   assign serial_data_oe  = sdo_oe_q;
   assign result_word     = s.result_word;
   assign result_ready    = s.result_ready;
   assign conv_active     = s.conv_active;
   assign setup_options   = s.setup_options;

endmodule

// ### dv/adcp_serial_port_properties.sv
// concurrent checks on the serial command port boundary
`timescale 1ns/1ps
module adcp_serial_port_properties (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        ce,
   input wire logic        master_clock_input,
   input wire logic [23:0] adc_sample,
   input wire logic        serial_clock,
   input wire logic        chip_select_n,
   input wire logic        serial_data_in,
   input wire logic        serial_data_out,
   input wire logic        serial_data_oe,
   input wire logic [23:0] result_word,
   input wire logic        result_ready,
   input wire logic        conv_active,
   input wire logic [23:0] setup_options
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   // output driver is live only inside a frame
   a_oe_cs_high: assert property (
      chip_select_n |-> !serial_data_oe)
      else $error("data out enabled with chip select high");
   // enable comes at a falling edge, never with the select itself
   a_oe_not_early: assert property (
      $fell(chip_select_n) |-> !serial_data_oe)
      else $error("data out enabled before any falling edge");
   // read data only moves while the serial clock is low
   a_sdo_on_fall: assert property (
      $changed(serial_data_out) |-> !serial_clock || chip_select_n)
      else $error("data out changed while serial clock high");
   // result strobe lasts one cycle
   a_ready_pulse: assert property (
      result_ready |=> !result_ready)
      else $error("result strobe longer than one cycle");
   // result word moves only together with its strobe
   a_result_hold: assert property (
      !result_ready |-> $stable(result_word))
      else $error("result word changed without strobe");
   // a result needs a running conversion
   a_ready_conv: assert property (
      $rose(result_ready) |-> $past(conv_active))
      else $error("result without conversion");
   // set-up copy moves only through a serial write
   a_setup_frame: assert property (
      $changed(setup_options) |-> !chip_select_n)
      else $error("set-up copy changed outside a frame");
   // conversions start only from a command inside a frame
   a_conv_frame: assert property (
      $rose(conv_active) |-> !chip_select_n)
      else $error("conversion started outside a frame");
endmodule

bind adcp_serial_port adcp_serial_port_properties u_props (
   .sys_clk(sys_clk), .reset(reset), .ce(ce),
   .master_clock_input(master_clock_input), .adc_sample(adc_sample),
   .serial_clock(serial_clock), .chip_select_n(chip_select_n),
   .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
   .serial_data_oe(serial_data_oe), .result_word(result_word),
   .result_ready(result_ready), .conv_active(conv_active),
   .setup_options(setup_options)
);

// ### dv/adcp_host_model.sv
// host side of the four-wire serial bus
`timescale 1ns/1ps
module adcp_host_model (
   output logic       serial_clock,
   output logic       chip_select_n,
   output logic       serial_data_in,
   input  wire logic  serial_data_out,
   input  wire logic  serial_data_oe
);
   initial begin
      serial_clock   = 1'b0;
      chip_select_n  = 1'b1;
      serial_data_in = 1'b0;
   end

   // one frame of n bits taken from din[n-1:0], msb first
   task automatic xfer(input int n, input logic [79:0] din,
                       output logic [79:0] dout);
      dout = 80'h0;
      chip_select_n = 1'b0;
      #30;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = din[i];
         #24;
         dout[i] = serial_data_out;
         serial_clock = 1'b1;
         #24;
         serial_clock = 1'b0;
      end
      #100;
      chip_select_n = 1'b1;
      // released line shows no stale bit
      serial_data_in = ~serial_data_in;
      #50;
   endtask
endmodule

// ### dv/tb_adc_serial_command_port.sv
// self-checking bench for the serial command port
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); \
   end end
module tb_adc_serial_command_port;
   logic        sys_clk;
   logic        reset;
   logic        ce;
   logic        master_clock_input;
   logic [23:0] adc_sample;
   wire         serial_clock;
   wire         chip_select_n;
   wire         serial_data_in;
   wire         serial_data_out;
   wire         serial_data_oe;
   wire  [23:0] result_word;
   wire         result_ready;
   wire         conv_active;
   wire  [23:0] setup_options;
   int          err_count;
   int          tests_run;
   int          seed;
   int          cycles;
   int          medges;
   logic [79:0] q;
   logic [23:0] d;
   logic [23:0] v [3];
   logic [71:0] g;
   logic [23:0] raw;
   logic [23:0] gn;

   adcp_serial_port u_adcp_serial_port (
      .sys_clk(sys_clk), .reset(reset), .ce(ce),
      .master_clock_input(master_clock_input), .adc_sample(adc_sample),
      .serial_clock(serial_clock), .chip_select_n(chip_select_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe), .result_word(result_word),
      .result_ready(result_ready), .conv_active(conv_active),
      .setup_options(setup_options)
   );

   adcp_host_model u_adcp_host_model (
      .serial_clock(serial_clock), .chip_select_n(chip_select_n),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe)
   );

   // clocks, master edge count and hang guard
   initial sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;
   always #20 master_clock_input = ~master_clock_input;
   always @(posedge master_clock_input) medges++;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 100000) begin
         err_count++;
         final_report();
      end
   end

   // calibrated result, unsigned 2.22 gain, saturated to 24 bits
   function automatic logic [23:0] calc(logic [23:0] r, logic [23:0] k);
      longint x;
      x = (longint'($signed(r)) * longint'({1'b0, k})) >>> 22;
      if (x > 64'sh7FFFFF) x = 64'sh7FFFFF;
      if (x < -64'sh800000) x = -64'sh800000;
      return x[23:0];
   endfunction

   // master clock edges of one word period
   function automatic int edges(input int r);
      case (r)
         4: return 1092;
         5: return 532;
         6: return 388;
         default: return 324;
      endcase
   endfunction

   task automatic wr(input logic [7:0] c, input logic [23:0] w);
      u_adcp_host_model.xfer(32, {48'h0, c, w}, q);
   endtask

   task automatic rd(input logic [7:0] c, output logic [23:0] w);
      u_adcp_host_model.xfer(32, {48'h0, c, 24'h000000}, q);
      w = q[23:0];
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      seed = 12;
      reset = 1'b1;
      ce = 1'b1;
      master_clock_input = 1'b0;
      adc_sample = 24'h000000;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk) reset = 1'b0;
      `CHK(setup_options, 24'h000000)
      u_adcp_host_model.xfer(4, 80'hF, q);
      rd(8'h92, d); `CHK(d, 24'h400000)
      rd(8'h90, d); `CHK(d, 24'h000000)
      done("reset");
      for (int k = 0; k < 3; k++) begin
         v[k] = $random(seed);
         wr(8'h80 | 8'(k << 1), v[k]);
      end
      for (int k = 0; k < 3; k++) begin
         rd(8'h90 | 8'(k << 1), d); `CHK(d, v[k])
      end
      `CHK(setup_options, v[2])
      wr(8'h86, ~v[0]); rd(8'h96, d); `CHK(d, 24'h000000)
      for (int s = 5; s < 8; s++) wr(8'h80 | 8'(s << 1), 24'h000000);
      for (int k = 0; k < 3; k++) begin
         rd(8'h90 | 8'(k << 1), d); `CHK(d, v[k])
      end
      u_adcp_host_model.xfer(40, {40'h0, 16'h0092, 24'h0}, q);
      `CHK(q[23:0], v[1])
      done("registers");
      g = {$random(seed), $random(seed), $random(seed)};
      u_adcp_host_model.xfer(80, {8'h88, g}, q);
      u_adcp_host_model.xfer(80, {8'h98, 72'h0}, q);
      `CHK(q[71:0], g)
      `CHK(setup_options, g[23:0])
      done("group");
      for (int r = 4; r < 8; r++) begin
         raw = (r == 7) ? 24'h7FFFFF : 24'($random(seed));
         gn = (r == 7) ? 24'hFFFFFF : 24'($random(seed));
         wr(8'h80, 24'h000000);
         wr(8'h82, gn);
         wr(8'h84, 24'(r));
         @(negedge sys_clk) adc_sample = raw;
         medges = 0;
         u_adcp_host_model.xfer(8, {72'h0, 8'hC0}, q);
         for (int t = 0; t < 20000; t++) begin
            @(negedge sys_clk);
            if (result_ready === 1'b1) break;
         end
         `CHK(result_word, calc(raw, gn))
         `CHK(medges >= edges(r) - 2 && medges <= edges(r) + 16, 1'b1)
         rd(8'h96, d); `CHK(d, calc(raw, gn))
      end
      done("conversion");
      // frozen clock enable: a write frame must not land
      @(negedge sys_clk) ce = 1'b0;
      wr(8'h84, 24'h00005A);
      @(negedge sys_clk) ce = 1'b1;
      `CHK(setup_options, 24'h000007)
      u_adcp_host_model.xfer(4, 80'hF, q);
      rd(8'h94, d); `CHK(d, 24'h000007)
      done("enable");
      final_report();
   end
endmodule
